/* core/touch_port_pkg.sv */
// Package for the touch controller host serial port.
// Assumes a single 125 MHz clock domain; I2C pins are asynchronous to it.
package touch_port_pkg;
    localparam logic [6:0]  TARGET_ADDR      = 7'h4A;
    localparam int          CLOCK_MHZ        = 125;
    localparam int          MEM_DEPTH        = 256;
    localparam int          BYTE_BITS        = 8;
    // Object addresses inside the device map
    localparam logic [15:0] VARIANT_ADDR     = 16'h0001;
    localparam logic [15:0] ENC_STATUS_ADDR  = 16'h0010;
    localparam logic [15:0] SERIAL_CMD_ADDR  = 16'h0020;
    localparam logic [15:0] CMD_PROC_ADDR    = 16'h0030;
    // Field positions
    localparam int          VARIANT_ENC_BIT  = 7;
    localparam int          ENC_CFG_BIT      = 0;
    localparam int          ENC_MSG_BIT      = 1;
    localparam int          COMMS_ERR_BIT    = 2;
    localparam int          RW_BIT           = 0;
    // Reset values and CRC polynomial
    localparam logic [7:0]  VARIANT_RESET    = 8'h01;
    localparam logic [1:0]  ENC_RESET        = 2'h0;
    localparam logic [7:0]  CRC_INIT         = 8'h00;
    localparam logic [7:0]  CRC_POLY         = 8'h07;

    typedef struct packed {
        logic cfg;
        logic msg;
    } enc_modes_t;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_ADDR  = 6'b000010,
        ST_SIZE  = 6'b000100,
        ST_WDATA = 6'b001000,
        ST_RDATA = 6'b010000,
        ST_SKIP  = 6'b100000
    } port_state_t;
endpackage

/* core/touch_ctrl_host_i2c_port.sv */
// I2C target port of a touchscreen controller with change-notify and encryption state.
// Assumes scl/sda arrive asynchronously; open-drain sda is split into in/out/enable.
//
// Behaviour
// [R1] Respond only at fixed 7-bit address 0x4A, no alternative address.
// [R2] Host puts address in bits 7..1, direction flag in bit 0.
// [R3] Drive change_notify_n low while a new data packet waits.
// [R4] Unencrypted after power-up until encryption requested and armed.
// [R5] Protected data uses AES-128 in CBC mode on both sides. This port has no AES datapath; it only flags the modes.
// [R6] Configuration and message encryption selectable independently, one or both.
// [R7] Encryption parameters written are pending; take effect at next reset.
// [R8] Variant identifier reads with bit 7 set while encryption active.
// [R9] Encryption status object shows which modes are in force.
// [R10] Write stores from pointer; STOP restores pointer to start value.
// [R11] Two-byte data size field follows address only when encryption active.
// [R12] Optional CRC over written bytes; mismatch raises comms_error_fault.
// [R13] Non-matching address is not acknowledged; rest of transfer ignored.
`timescale 1ns/1ps
module touch_ctrl_host_i2c_port
    import touch_port_pkg::*;
(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic packet_ready,
    output logic      change_notify_n,
    output logic      comms_error_fault,
    output logic [1:0] enc_active
);
    logic [1:0]  scl_sync, sda_sync;
    logic        scl_d, sda_d;
    logic [7:0]  mem [MEM_DEPTH];
    port_state_t state_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic        ack_phase_reg, rw_reg;
    logic [1:0]  hdr_cnt_reg;
    logic [15:0] ptr_reg, start_ptr_reg;
    logic [7:0]  crc_reg, last_byte_reg, crc_before_reg;
    logic        data_seen_reg;
    enc_modes_t  enc_reg;
    // Power-up value only; rstn leaves it alone so an armed request meets the reset
    enc_modes_t  pending_reg = ENC_RESET;
    logic [7:0]  rd_byte;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; only the second stage is used
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    wire scl_rise = scl_sync[1] & ~scl_d;
    wire scl_fall = ~scl_sync[1] & scl_d;
    wire start_c  = scl_sync[1] & scl_d & ~sda_sync[1] & sda_d;
    wire stop_c   = scl_sync[1] & scl_d & sda_sync[1] & ~sda_d;
    wire byte_done = scl_rise & (bit_cnt_reg == 4'h7) & ~ack_phase_reg;
    wire [7:0] rx_byte = {shift_reg[6:0], sda_sync[1]};

    // Bitwise CRC-8 step over one byte
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // Read mux: live objects overlay the memory
    always_comb begin
        rd_byte = mem[ptr_reg[7:0]];
        if (ptr_reg == VARIANT_ADDR) begin
            rd_byte = VARIANT_RESET;
            rd_byte[VARIANT_ENC_BIT] = enc_reg.cfg | enc_reg.msg;       // see [R8]
        end else if (ptr_reg == ENC_STATUS_ADDR) begin
            rd_byte = {6'h00, enc_reg.msg, enc_reg.cfg};               // see [R9]
        end else if (ptr_reg == CMD_PROC_ADDR) begin
            rd_byte = {5'h00, comms_error_fault, 2'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit and byte framing on scl edges
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= ST_IDLE;
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= 4'h0;
            ack_phase_reg <= 1'b0;
            rw_reg        <= 1'b0;
            hdr_cnt_reg   <= 2'h0;
        end else if (start_c) begin
            state_reg     <= ST_ADDR;
            bit_cnt_reg   <= 4'h0;
            ack_phase_reg <= 1'b0;
        end else if (stop_c) begin
            state_reg <= ST_IDLE;
        end else if (state_reg != ST_IDLE && state_reg != ST_SKIP) begin
            if (scl_rise && !ack_phase_reg) begin
                shift_reg   <= rx_byte;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (byte_done) begin
                ack_phase_reg <= 1'b1;
                case (state_reg)
                    ST_ADDR: begin
                        // Address in 7..1, direction in bit 0; see [R2]
                        if (rx_byte[7:1] != TARGET_ADDR) begin
                            state_reg <= ST_SKIP;                      // see [R1] [R13]
                        end else begin
                            rw_reg      <= rx_byte[RW_BIT];
                            hdr_cnt_reg <= 2'h0;
                            state_reg   <= rx_byte[RW_BIT] ? ST_RDATA : ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        if (hdr_cnt_reg == 2'h1 && (enc_reg.cfg | enc_reg.msg))
                            state_reg <= ST_SIZE;                      // see [R11]
                        if (hdr_cnt_reg != 2'h3)
                            hdr_cnt_reg <= hdr_cnt_reg + 2'h1;
                    end
                    ST_SIZE: begin
                        // Counter parks at 3 so the data bytes that follow are not
                        // mistaken for a new pointer
                        if (hdr_cnt_reg == 2'h3)
                            state_reg <= ST_WDATA;                     // see [R11]
                        else
                            hdr_cnt_reg <= hdr_cnt_reg + 2'h1;
                    end
                    ST_RDATA: begin
                        // Marks a data byte: the host, not the port, answers it
                        hdr_cnt_reg <= 2'h3;
                    end
                    default: ;
                endcase
            end else if (scl_rise && ack_phase_reg && bit_cnt_reg == 4'h9 &&
                         state_reg == ST_RDATA && hdr_cnt_reg == 2'h3 && sda_sync[1]) begin
                // Host declined the byte: stay off the bus until STOP or START
                state_reg <= ST_SKIP;
            end else if (scl_fall && ack_phase_reg && bit_cnt_reg == 4'h8) begin
                bit_cnt_reg <= 4'h9;
            end else if (scl_fall && bit_cnt_reg == 4'h9) begin
                ack_phase_reg <= 1'b0;
                bit_cnt_reg   <= 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write pointer, storage and pointer restore at STOP
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ptr_reg       <= 16'h0000;
            start_ptr_reg <= 16'h0000;
            data_seen_reg <= 1'b0;
        end else if (stop_c && !rw_reg && state_reg == ST_WDATA) begin
            ptr_reg <= start_ptr_reg;                                  // see [R10]
        end else if (start_c) begin
            data_seen_reg <= 1'b0;
        end else if (byte_done && state_reg == ST_WDATA) begin
            if (hdr_cnt_reg == 2'h0) begin
                ptr_reg[7:0] <= rx_byte;
            end else if (hdr_cnt_reg == 2'h1) begin
                ptr_reg[15:8]       <= rx_byte;
                start_ptr_reg       <= {rx_byte, ptr_reg[7:0]};
            end else begin
                ptr_reg       <= ptr_reg + 16'h0001;                   // see [R10]
                data_seen_reg <= 1'b1;
            end
        end else if (scl_rise && bit_cnt_reg == 4'h9 && state_reg == ST_RDATA
                     && hdr_cnt_reg == 2'h3) begin
            // Step at the host's answer so the next byte is ready at the fall
            ptr_reg <= ptr_reg + 16'h0001;
        end
    end

    // Memory store; bytes are plain, decryption lives in the object engine
    always_ff @(posedge clock) begin
        if (byte_done && state_reg == ST_WDATA && hdr_cnt_reg >= 2'h2)
            mem[ptr_reg[7:0]] <= rx_byte;
    end

    ////////////////////////////////////////////////////////////////////////
    // Running CRC; last byte of a write is taken as the optional checksum
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            crc_reg           <= CRC_INIT;
            crc_before_reg    <= CRC_INIT;
            last_byte_reg     <= 8'h00;
            comms_error_fault <= 1'b0;
        end else if (start_c) begin
            crc_reg <= CRC_INIT;
        end else if (byte_done && (state_reg == ST_WDATA || state_reg == ST_SIZE)) begin
            crc_before_reg <= crc_reg;
            crc_reg        <= crc8(crc_reg, rx_byte);                  // see [R12]
            last_byte_reg  <= rx_byte;
        end else if (stop_c && state_reg == ST_WDATA && data_seen_reg) begin
            // Mismatch is sticky until reset; set only, never cleared here
            if (last_byte_reg != crc_before_reg && crc_reg != CRC_INIT)
                comms_error_fault <= 1'b1;                             // see [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Encryption: writes to the command object only arm pending modes
    // No reset on purpose: pending modes must outlive the reset that arms them
    always_ff @(posedge clock) begin
        if (byte_done && state_reg == ST_WDATA && hdr_cnt_reg >= 2'h2
                     && ptr_reg == SERIAL_CMD_ADDR) begin
            pending_reg.cfg <= rx_byte[ENC_CFG_BIT];                   // see [R6] [R7]
            pending_reg.msg <= rx_byte[ENC_MSG_BIT];
        end
    end

    // Active modes are loaded from pending on the first edge after reset release.
    // Pending survives only as a register value; a power-up starts with none armed.
    logic loaded_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            enc_reg    <= '0;                                          // see [R4]
            loaded_reg <= 1'b0;
        end else if (!loaded_reg) begin
            enc_reg    <= pending_reg;                                 // see [R7]
            loaded_reg <= 1'b1;
        end
    end
    // AES-128 CBC datapath sits in the object engine; this port only flags modes. see [R5]
    assign enc_active = {enc_reg.msg, enc_reg.cfg};

    ////////////////////////////////////////////////////////////////////////
    // Open-drain sda: ack on header/data, drive read bits
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else if (scl_fall && ack_phase_reg && bit_cnt_reg == 4'h8 &&
                     state_reg != ST_SKIP && !(state_reg == ST_RDATA && hdr_cnt_reg == 2'h3)) begin
            sda_oe  <= ~(state_reg == ST_RDATA && rw_reg && bit_cnt_reg != 4'h8);
            sda_out <= 1'b0;
        end else if (scl_fall && state_reg == ST_RDATA &&
                     (!ack_phase_reg || bit_cnt_reg == 4'h9)) begin
            // Leaving the ack slot puts out the top bit; later falls step down
            sda_oe  <= ~rd_byte[ack_phase_reg ? 3'h7 : 3'h7 - bit_cnt_reg[2:0]];
            sda_out <= 1'b0;
        end else if (scl_fall || stop_c || start_c) begin
            sda_oe  <= 1'b0;
        end
    end

    // Change-notify follows the packet flag; registered so it never glitches
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            change_notify_n <= 1'b1;
        else
            change_notify_n <= ~packet_ready;                          // see [R3]
    end
endmodule

/* tb/touch_port_checker.sv */
// Checker for the touch host serial port, ports only.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/1ps
module touch_port_checker (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       scl_in,
    input wire logic       packet_ready,
    input wire logic       sda_oe,
    input wire logic       change_notify_n,
    input wire logic       comms_error_fault,
    input wire logic [1:0] enc_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [1:0] up_cnt_reg;
    // Saturating age since reset; grace for the mode load
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) up_cnt_reg <= 2'h0;
        else if (up_cnt_reg != 2'h3) up_cnt_reg <= up_cnt_reg + 2'h1;
    end
    AST_NOTIFY_SET: assert property (packet_ready |=> !change_notify_n)
        else $error("notify not active after packet");
    AST_NOTIFY_CLR: assert property (!packet_ready |=> change_notify_n)
        else $error("notify active without packet");
    AST_MODES_HELD: assert property (up_cnt_reg == 2'h3 |-> $stable(enc_active))
        else $error("modes changed outside reset");
    AST_FAULT_STICKY: assert property (comms_error_fault |=> comms_error_fault)
        else $error("fault dropped without reset");
    AST_RESET_CLEAR: assert property (!$past(rstn) |-> !comms_error_fault && !sda_oe)
        else $error("state not clear after reset");
    AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("ack raised with scl high");
    AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe[*8])
        else $error("ack too short");
    AST_SDA_STEADY: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    cover property (!change_notify_n);
    cover property ($rose(sda_oe));
    cover property ($rose(comms_error_fault));
    cover property (enc_active == 2'h3);
endmodule
bind touch_ctrl_host_i2c_port touch_port_checker i_touch_port_checker (
    .clock(clock), .rstn(rstn), .scl_in(scl_in), .packet_ready(packet_ready),
    .sda_oe(sda_oe), .change_notify_n(change_notify_n),
    .comms_error_fault(comms_error_fault), .enc_active(enc_active));

/* tb/i2c_host_model.sv */
// Behavioural I2C controller on the port's pins.
// Assumes a pull-up on sda; the port pulls low through sda_oe.
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic clock,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic sda_h = 1'b1;
    initial scl = 1'b1;
    // Wired-and; a released line reads high
    assign sda = sda_h & ~sda_oe;
    // Third of a bit, slow next to the port's sync lag
    task automatic hold();
        repeat (20) @(posedge clock);
        #1;
    endtask
    // Data moves only while scl low
    task automatic clk_bit();
        hold();
        scl = 1'b1;
        hold();
        scl = 1'b0;
        hold();
    endtask
    task automatic start_cond();
        sda_h = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_h = 1'b0;
        hold();
        scl = 1'b0;
        hold();
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_h = b[i];
            clk_bit();
        end
        sda_h = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        ack = ~sda;
        scl = 1'b0;
        hold();
    endtask
    // One byte from the port, declined so the port lets go of the line
    task automatic recv_byte(output logic [7:0] b);
        sda_h = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            hold();
            scl = 1'b1;
            hold();
            b[i] = sda;
            scl = 1'b0;
        end
        clk_bit();
    endtask
    task automatic stop_cond();
        sda_h = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_h = 1'b1;
        hold();
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the touch host serial port.
// Assumes the host model and checker files compiled before it.
`timescale 1ns/1ps
module tb_top;
    import touch_port_pkg::*;
    logic       clock = 1'b0;
    logic       rstn = 1'b0;
    logic       packet_ready = 1'b0;
    logic       scl, sda, sda_out, sda_oe, change_notify_n, comms_error_fault;
    logic [1:0] enc_active;
    logic       ack;
    int         n_mismatch = 0;
    int         n_tests = 0;
    always #4 clock = ~clock;
    i2c_host_model i_i2c_host_model (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    touch_ctrl_host_i2c_port i_touch_ctrl_host_i2c_port (.clock(clock), .rstn(rstn),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .packet_ready(packet_ready), .change_notify_n(change_notify_n),
        .comms_error_fault(comms_error_fault), .enc_active(enc_active));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bitwise CRC-8, the host's own copy
    function automatic logic [7:0] crc8(input logic [7:0] q[$]);
        logic [7:0] c;
        c = CRC_INIT;
        foreach (q[i]) begin
            c = c ^ q[i];
            repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task automatic do_reset();
        rstn = 1'b0;
        repeat (4) @(posedge clock);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clock);
        #1;
    endtask
    // One-byte write with trailing CRC; size bytes only when encrypted
    task automatic wr(input logic [7:0] ab, input logic [15:0] p, input logic [7:0] d,
                      input logic sz, input logic bad, output logic a0);
        logic [7:0] q[$];
        logic       a;
        q = {p[7:0], p[15:8]};
        if (sz) q = {q, 8'h00, 8'h00};
        q.push_back(d);
        q.push_back(crc8(q) ^ {7'h00, bad});
        q.push_front(ab);
        i_i2c_host_model.start_cond();
        foreach (q[i]) begin
            i_i2c_host_model.send_byte(q[i], a);
            if (i == 0) a0 = a;
        end
        i_i2c_host_model.stop_cond();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // One-byte read at the current pointer, declined by the host
    task automatic rd_here(output logic [7:0] d);
        logic a;
        i_i2c_host_model.start_cond();
        i_i2c_host_model.send_byte({TARGET_ADDR, 1'b1}, a);
        i_i2c_host_model.recv_byte(d);
        i_i2c_host_model.stop_cond();
        check("ack read", 8'h01, {7'h00, a});
    endtask
    // Pointer set by a data-less write, then a read; size bytes only when encrypted
    task automatic rd_at(input logic [15:0] p, input logic sz, output logic [7:0] d);
        logic a;
        i_i2c_host_model.start_cond();
        i_i2c_host_model.send_byte({TARGET_ADDR, 1'b0}, a);
        i_i2c_host_model.send_byte(p[7:0], a);
        i_i2c_host_model.send_byte(p[15:8], a);
        if (sz) begin
            i_i2c_host_model.send_byte(8'h00, a);
            i_i2c_host_model.send_byte(8'h00, a);
        end
        i_i2c_host_model.stop_cond();
        rd_here(d);
    endtask
    task automatic t_address();
        wr({TARGET_ADDR ^ 7'h01, 1'b0}, 16'h0040, 8'h11, 1'b0, 1'b0, ack);
        check("ack foreign", 8'h00, {7'h00, ack});
        wr({TARGET_ADDR, 1'b0}, 16'h0040, 8'h11, 1'b0, 1'b0, ack);
        check("ack own", 8'h01, {7'h00, ack});
    endtask
    task automatic t_notify();
        packet_ready = 1'b1;
        repeat (2) @(posedge clock);
        #1 check("notify on", 8'h00, {7'h00, change_notify_n});
        packet_ready = 1'b0;
        repeat (2) @(posedge clock);
        #1 check("notify off", 8'h01, {7'h00, change_notify_n});
    endtask
    task automatic t_crc();
        check("fault good", 8'h00, {7'h00, comms_error_fault});
        wr({TARGET_ADDR, 1'b0}, 16'h0040, 8'h22, 1'b0, 1'b1, ack);
        check("fault bad", 8'h01, {7'h00, comms_error_fault});
    endtask
    // Plain-mode reads: pointer back at the last write's start, then the objects
    task automatic t_read();
        logic [7:0] d;
        rd_here(d);
        check("pointer restored", 8'h22, d);
        rd_at(VARIANT_ADDR, 1'b0, d);
        check("variant plain", {1'b0, VARIANT_RESET[6:0]}, d);
        rd_at(ENC_STATUS_ADDR, 1'b0, d);
        check("status plain", 8'h00, d);
        check("sda level", 8'h00, {7'h00, sda_out});
    endtask
    // Pending modes load only at reset
    task automatic t_modes();
        logic [7:0] d;
        wr({TARGET_ADDR, 1'b0}, SERIAL_CMD_ADDR, 8'h02, 1'b0, 1'b0, ack);
        check("modes pending", 8'h00, {6'h00, enc_active});
        do_reset();
        check("modes msg", 8'h02, {6'h00, enc_active});
        check("fault cleared", 8'h00, {7'h00, comms_error_fault});
        rd_at(ENC_STATUS_ADDR, 1'b1, d);
        check("status msg", 8'h02, d);
        wr({TARGET_ADDR, 1'b0}, SERIAL_CMD_ADDR, 8'h03, 1'b1, 1'b0, ack);
        check("modes held", 8'h02, {6'h00, enc_active});
        do_reset();
        check("modes both", 8'h03, {6'h00, enc_active});
        rd_at(VARIANT_ADDR, 1'b1, d);
        check("variant enc", {1'b1, VARIANT_RESET[6:0]}, d);
        rd_at(ENC_STATUS_ADDR, 1'b1, d);
        check("status both", 8'h03, d);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        do_reset();
        check("modes at power-up", 8'h00, {6'h00, enc_active});
        t_address();
        t_notify();
        t_crc();
        t_read();
        t_modes();
        summarize();
    end
    // Whole run takes about 270 us
    initial begin
        #600000;
        n_mismatch++;
        summarize();
    end
endmodule
